//--- hdl/bcrf_pkg.sv
/*
  bcrf_pkg: constants and types shared by the banked cpu register file.
  assumes one cpu clock where one clock period is one t-state.
*/
`default_nettype none
package bcrf_pkg;
  localparam int DATA_W  = 8;
  localparam int REG_AW  = 5;
  localparam int PHYS_N  = 44;
  localparam int IDX_N   = 4;
  // logical locations
  localparam logic [4:0] GROUP_A_END   = 5'h04;
  localparam logic [4:0] GROUP_B_END   = 5'h0c;
  localparam logic [4:0] ACC_LOC       = 5'h08;
  localparam logic [4:0] LINE_PORT_LOC = 5'h04;
  localparam logic [4:0] IMM_MASK      = 5'h0f;
  localparam logic [5:0] IDX_BASE_PH   = 6'h18;
  // physical storage bases
  localparam logic [5:0] PH_MAIN_A = 6'h00;
  localparam logic [5:0] PH_ALT_A  = 6'h04;
  localparam logic [5:0] PH_MAIN_B = 6'h08;
  localparam logic [5:0] PH_ALT_B  = 6'h10;
  localparam logic [5:0] PH_COMMON = 6'h18;
  // t-state counts before wait states
  localparam logic [4:0] TS_SHORT  = 5'h02;
  localparam logic [4:0] TS_BRANCH = 5'h03;
  localparam logic [4:0] TS_MEM    = 5'h04;
  // reset values
  localparam logic       RST_A_ALT = 1'b1;
  localparam logic       RST_B_ALT = 1'b1;
  localparam logic       RST_GIE   = 1'b0;
  localparam logic [7:0] RST_REG   = 8'h00;
  // bank exchange argument bits
  localparam int EXX_A_BIT  = 0;
  localparam int EXX_B_BIT  = 1;
  localparam int EXX_IE_BIT = 2;
  localparam int EXX_ID_BIT = 3;

  typedef enum logic [2:0] {
    OP_ALU = 3'b000, OP_MOVE = 3'b001, OP_LDI = 3'b010, OP_MRD = 3'b011,
    OP_MWR = 3'b100, OP_BRANCH = 3'b101, OP_EXX = 3'b110, OP_PLOAD = 3'b111
  } bcrf_op_e;
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000, ALU_SUB = 3'b001, ALU_AND = 3'b010, ALU_OR = 3'b011,
    ALU_XOR = 3'b100, ALU_SHL = 3'b101, ALU_ROR = 3'b110, ALU_PASS = 3'b111
  } bcrf_alu_e;
  typedef enum logic [1:0] {
    IDX_HOLD = 2'b00, IDX_INC = 2'b01, IDX_DEC = 2'b10, IDX_KEEP = 2'b11
  } bcrf_idx_e;
  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} bcrf_st_e;
endpackage
`default_nettype wire

//--- hdl/bcrf_regfile.sv
/*
  bcrf_regfile: banked 8-bit register file with its alu/mux data path,
  t-state sequencing, index addressing and line data port.
  assumes the decoder holds an instruction on instr_* with instr_valid
  until it sees the cycle where ready is high; fifo and memory sides
  answer within the instruction's t-states.
*/
`timescale 1ns/1ps
`default_nettype none
module bcrf_regfile
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               instr_valid,
  input  wire bcrf_pkg::bcrf_op_e instr_op,
  input  wire bcrf_pkg::bcrf_alu_e alu_fn,
  input  wire logic [4:0]         src_addr,
  input  wire logic [4:0]         dst_addr,
  input  wire logic               use_imm,
  input  wire logic [7:0]         imm_data,
  input  wire logic               dst_write,
  input  wire logic [1:0]         idx_sel,
  input  wire bcrf_pkg::bcrf_idx_e idx_mode,
  input  wire logic [1:0]         iw_wait,
  input  wire logic [2:0]         dw_wait,
  input  wire logic [7:0]         rx_data,
  input  wire logic [7:0]         mem_rd_data,
  output logic                    ready,
  output logic                    done,
  output logic                    fetch_next,
  output logic                    tx_push,
  output logic [7:0]              tx_data,
  output logic                    rx_pop,
  output logic [15:0]             mem_addr,
  output logic [7:0]              mem_wr_data,
  output logic                    mem_we,
  output logic                    mem_re,
  output logic                    prog_we,
  output logic                    bank_a_alt,
  output logic                    bank_b_alt,
  output logic                    gie
);
  import bcrf_pkg::*;

  // map a logical location to physical storage under the current banks
  function automatic logic [5:0] phys_of(input logic [4:0] a, input logic alt_a,
                                         input logic alt_b);
    if (a < GROUP_A_END)
      phys_of = (alt_a ? PH_ALT_A : PH_MAIN_A) + {1'b0, a};
    else if (a < GROUP_B_END)
      phys_of = (alt_b ? PH_ALT_B : PH_MAIN_B) + {1'b0, a - GROUP_A_END};
    else
      phys_of = PH_COMMON + {1'b0, a - GROUP_B_END};
  endfunction

  logic [7:0]  rf_q [PHYS_N];
  bcrf_st_e    state_q;
  logic [4:0]  cnt_q;
  bcrf_op_e    op_q;
  logic [5:0]  dst_ph_q;
  logic [7:0]  res_q;
  logic        wr_reg_q, wr_port_q;
  logic [1:0]  idx_sel_q;
  bcrf_idx_e   idx_mode_q;
  logic [3:0]  exx_arg_q;
  logic        done_q, fetch_q, tx_push_q, rx_pop_q, mem_we_q, mem_re_q, prog_we_q;
  logic [7:0]  tx_data_q, mem_wdata_q;
  logic [15:0] mem_addr_q;
  logic        a_alt_q, b_alt_q, gie_q, ready_q;

  // decode of the offered instruction
  wire        accept    = instr_valid && (state_q == ST_IDLE);
  wire [4:0]  dst_eff   = use_imm ? (dst_addr & IMM_MASK) : dst_addr;
  wire [5:0]  src_ph    = phys_of(src_addr, a_alt_q, b_alt_q);
  wire [5:0]  dst_ph    = phys_of(dst_eff, a_alt_q, b_alt_q);
  wire [5:0]  acc_ph    = phys_of(ACC_LOC, a_alt_q, b_alt_q);
  wire        src_port  = b_alt_q && (src_addr == LINE_PORT_LOC);
  wire        dst_port  = b_alt_q && (dst_eff == LINE_PORT_LOC);
  wire        reads_src = ((instr_op == OP_ALU) && !use_imm) || (instr_op == OP_MOVE) ||
                          (instr_op == OP_MWR);
  wire        is_mem    = (instr_op == OP_MRD) || (instr_op == OP_MWR);
  wire        writes    = dst_write && ((instr_op == OP_ALU) || (instr_op == OP_MOVE) ||
                          (instr_op == OP_LDI) || (instr_op == OP_MRD));

  // source bus and accumulator operand; reads never disturb writes
  wire [7:0]  src_bus   = src_port ? rx_data : rf_q[src_ph];
  wire [7:0]  acc_val   = rf_q[acc_ph];
  wire [7:0]  opnd      = use_imm ? imm_data : src_bus;
  wire [15:0] idx_ptr   = {rf_q[IDX_BASE_PH + {3'h0, idx_sel, 1'b1}],
                           rf_q[IDX_BASE_PH + {3'h0, idx_sel, 1'b0}]};

  // alu/mux: only alu ops pass here on the way to the destination bus; ldi and moves bypass it
  logic [7:0] alu_out;
  always_comb
  begin
    unique case (alu_fn)
      ALU_ADD:  alu_out = opnd + acc_val;
      ALU_SUB:  alu_out = opnd - acc_val;
      ALU_AND:  alu_out = opnd & acc_val;
      ALU_OR:   alu_out = opnd | acc_val;
      ALU_XOR:  alu_out = opnd ^ acc_val;
      ALU_SHL:  alu_out = {opnd[6:0], 1'b0};
      ALU_ROR:  alu_out = {opnd[0], opnd[7:1]};
      ALU_PASS: alu_out = opnd;
    endcase
  end

  wire [7:0] dst_bus = (instr_op == OP_ALU) ? alu_out :
                       (instr_op == OP_LDI) ? imm_data : src_bus;

  // t-state budget: instruction waits always, data waits on memory only
  wire [4:0] base_ts = is_mem ? TS_MEM :
                       (instr_op == OP_BRANCH) ? TS_BRANCH : TS_SHORT;
  wire [4:0] total_ts = base_ts + {3'h0, iw_wait} +
                        (is_mem ? {2'h0, dw_wait} : 5'h00);
  wire       last = (state_q == ST_EXEC) && (cnt_q == 5'h01);

  // value written back at the last t-state; memory reads land late
  wire [7:0] wb_val = (op_q == OP_MRD) ? mem_rd_data : res_q;
  wire [15:0] idx_next = (idx_mode_q == IDX_INC) ? mem_addr_q + 16'h0001 :
                         (idx_mode_q == IDX_DEC) ? mem_addr_q - 16'h0001 : mem_addr_q;

  // sequencer; a new instruction is taken no earlier than the cycle after the last one ends
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
    end
    else if (accept)
    begin
      state_q <= ST_EXEC;
      cnt_q   <= total_ts - 5'h01;
    end
    else if (last)
      state_q <= ST_IDLE;
    else if (state_q == ST_EXEC)
      cnt_q <= cnt_q - 5'h01;
  end

  // latch the instruction at accept so the decoder may move on
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      op_q       <= OP_MOVE;
      dst_ph_q   <= 6'h00;
      res_q      <= RST_REG;
      wr_reg_q   <= 1'b0;
      wr_port_q  <= 1'b0;
      idx_sel_q  <= 2'h0;
      idx_mode_q <= IDX_HOLD;
      exx_arg_q  <= 4'h0;
    end
    else if (accept)
    begin
      op_q       <= instr_op;
      dst_ph_q   <= dst_ph;
      res_q      <= dst_bus;
      wr_reg_q   <= writes && !dst_port;
      wr_port_q  <= writes && dst_port;
      idx_sel_q  <= idx_sel;
      idx_mode_q <= is_mem ? idx_mode : IDX_HOLD;
      exx_arg_q  <= imm_data[3:0];
    end
  end

  // pulses and pins; fetch of the next word starts with execution
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      fetch_q     <= 1'b0;
      ready_q     <= 1'b1;
      done_q      <= 1'b0;
      rx_pop_q    <= 1'b0;
      tx_push_q   <= 1'b0;
      tx_data_q   <= 8'h00;
      mem_we_q    <= 1'b0;
      mem_re_q    <= 1'b0;
      prog_we_q   <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
    end
    else
    begin
      fetch_q   <= accept;
      ready_q   <= last || (ready_q && !accept);
      done_q    <= last;
      rx_pop_q  <= accept && reads_src && src_port;
      tx_push_q <= last && wr_port_q;
      if (last && wr_port_q)
        tx_data_q <= res_q;
      if (accept)
      begin
        mem_we_q    <= instr_op == OP_MWR;
        mem_re_q    <= instr_op == OP_MRD;
        prog_we_q   <= instr_op == OP_PLOAD;
        mem_addr_q  <= is_mem ? idx_ptr : mem_addr_q;
        mem_wdata_q <= (instr_op == OP_MWR) ? dst_bus : mem_wdata_q;
      end
      else if (last)
      begin
        mem_we_q  <= 1'b0;
        mem_re_q  <= 1'b0;
        prog_we_q <= 1'b0;
      end
    end
  end

  // bank selection; the host-side control register has no location here
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      a_alt_q <= RST_A_ALT;
      b_alt_q <= RST_B_ALT;
      gie_q   <= RST_GIE;
    end
    else if (last && (op_q == OP_EXX))
    begin
      a_alt_q <= exx_arg_q[EXX_A_BIT];
      b_alt_q <= exx_arg_q[EXX_B_BIT];
      if (exx_arg_q[EXX_IE_BIT])
        gie_q <= 1'b1;
      else if (exx_arg_q[EXX_ID_BIT])
        gie_q <= 1'b0;
    end
  end

  // storage; locations 12-31 map to fixed cells, the alt B cell of location 4 is written only by reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PHYS_N; i++)
        rf_q[i] <= RST_REG;
    end
    else if (last)
    begin
      if (wr_reg_q)
        rf_q[dst_ph_q] <= wb_val;
      if (idx_mode_q == IDX_INC || idx_mode_q == IDX_DEC)
      begin
        rf_q[IDX_BASE_PH + {3'h0, idx_sel_q, 1'b0}] <= idx_next[7:0];
        rf_q[IDX_BASE_PH + {3'h0, idx_sel_q, 1'b1}] <= idx_next[15:8];
      end
    end
  end

  // outputs straight from flops
  assign ready       = ready_q;
  assign done        = done_q;
  assign fetch_next  = fetch_q;
  assign tx_push     = tx_push_q;
  assign tx_data     = tx_data_q;
  assign rx_pop      = rx_pop_q;
  assign mem_addr    = mem_addr_q;
  assign mem_wr_data = mem_wdata_q;
  assign mem_we      = mem_we_q;
  assign mem_re      = mem_re_q;
  assign prog_we     = prog_we_q;
  assign bank_a_alt  = a_alt_q;
  assign bank_b_alt  = b_alt_q;
  assign gie         = gie_q;

  // helper: cycles since accept against the budget taken at accept
  logic [4:0] lat_q, exp_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lat_q <= 5'h00;
      exp_q <= 5'h00;
    end
    else if (accept)
    begin
      lat_q <= 5'h01;
      exp_q <= total_ts;
    end
    else if (state_q == ST_EXEC)
      lat_q <= lat_q + 5'h01;
  end

  sequence s_alu_take;
    accept && instr_op == OP_ALU && iw_wait == 2'h0;
  endsequence
  sequence s_alu_end;
    !done_q ##1 done_q;
  endsequence

  a_alu_two_tstates: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_alu_take |=> s_alu_end) else $error("short op did not end after two t-states");
  a_wait_budget: assert property (@(posedge sys_clk) disable iff (sys_rst)
    done_q |-> lat_q == exp_q) else $error("instruction length differs from wait budget");
  a_reset_alt_banks: assert property (@(posedge sys_clk)
    sys_rst |=> bank_a_alt && bank_b_alt && !gie) else $error("reset did not pick alternate banks");
  a_exx_bank_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(done_q) && op_q == OP_EXX |-> a_alt_q == exx_arg_q[EXX_A_BIT] &&
      b_alt_q == exx_arg_q[EXX_B_BIT]) else $error("exchange left wrong banks");
  a_fetch_overlap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept |=> fetch_next && state_q == ST_EXEC) else $error("fetch not overlapped");
  a_tx_push_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_push_q |-> done_q && tx_data_q == $past(res_q)) else $error("tx push off its end");
  a_rx_pop_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_pop_q |-> $past(accept) && !$past(rx_pop_q)) else $error("rx pop not at accept");
  a_mem_write_pins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && instr_op == OP_MWR |=> mem_we && mem_wr_data == $past(dst_bus) &&
      mem_addr == $past(idx_ptr)) else $error("memory write pins wrong");
  a_imm_low_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && use_imm && writes && !dst_port |=> dst_ph_q < (PH_COMMON + 6'h04))
    else $error("immediate form reached past location 15");
endmodule // bcrf_regfile
`default_nettype wire

//--- tb/bcrf_far_model.sv
/*
  bcrf_far_model: data memory and receive fifo beside the register file.
  assumes mem and fifo strobes from the regfile are registered levels.
*/
`timescale 1ns/1ps
`default_nettype none
module bcrf_far_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wr_data,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  input  wire logic        rx_pop,
  output logic [7:0]       mem_rd_data,
  output logic [7:0]       rx_data
);
  logic [7:0] mem [0:255];
  logic [7:0] junk;
  logic [7:0] rx_cnt;

  // memory holds a known pattern so reads are predictable
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    junk = 8'h3c;
    rx_cnt = 8'h00;
  end

  // only 256 bytes are kept; upper address bits alias
  always @(posedge sys_clk)
  begin
    if (mem_we)
      mem[mem_addr[7:0]] <= mem_wr_data;
    if (rx_pop)
      rx_cnt <= rx_cnt + 8'h01;
    junk <= ~junk;
  end

  // outside a read the bus shows a changing pattern, never stale data
  assign mem_rd_data = mem_re ? mem[mem_addr[7:0]] : junk;
  assign rx_data     = 8'hc0 + rx_cnt;
endmodule // bcrf_far_model
`default_nettype wire

//--- tb/tb_banked_cpu_register_file.sv
/*
  tb_banked_cpu_register_file: self-checking bench for bcrf_regfile.
  assumes the far model answers memory and receive fifo traffic.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_banked_cpu_register_file;
  import bcrf_pkg::*;
  typedef struct {logic [4:0] loc; logic [7:0] val;} bcrf_row_s;
  logic sys_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  bcrf_op_e   instr_op = OP_ALU;
  bcrf_alu_e  alu_fn = ALU_PASS;
  logic [4:0] src_addr = 5'h00, dst_addr = 5'h00;
  logic       use_imm = 1'b0, dst_write = 1'b0;
  logic [7:0] imm_data = 8'h00, rx_data, mem_rd_data, tx_data, mem_wr_data, dn_txd;
  logic [1:0] idx_sel = 2'h3, iw_wait = 2'h0, dn;
  bcrf_idx_e  idx_mode = IDX_HOLD;
  logic [2:0] dw_wait = 3'h0;
  logic       ready, done, fetch_next, tx_push, rx_pop, mem_we, mem_re, prog_we;
  logic       bank_a_alt, bank_b_alt, gie;
  logic [15:0] mem_addr, n1_addr;
  logic [5:0] n1;
  int         bad_count = 0;
  int         tests_run = 0;
  bcrf_row_s  rows [10] = '{'{5'h00, 8'h10}, '{5'h01, 8'h21}, '{5'h03, 8'h43},
    '{5'h05, 8'h65}, '{5'h09, 8'h89}, '{5'h0b, 8'hab}, '{5'h14, 8'h14},
    '{5'h15, 8'h95}, '{5'h1b, 8'hdb}, '{5'h1f, 8'hff}};
  bcrf_op_e   tops [6] = '{OP_BRANCH, OP_BRANCH, OP_ALU, OP_PLOAD, OP_MWR, OP_MRD};
  int         tiw [6] = '{0, 2, 1, 3, 1, 0};
  int         tdw [6] = '{0, 5, 7, 0, 2, 3};
  int         tt [6] = '{3, 5, 3, 5, 7, 7};
  logic [2:0] tfl [6] = '{3'b000, 3'b000, 3'b000, 3'b100, 3'b010, 3'b001};
  bcrf_idx_e  modes [4] = '{IDX_INC, IDX_DEC, IDX_HOLD, IDX_KEEP};
  logic [15:0] exa [4] = '{16'h0040, 16'h0041, 16'h0040, 16'h0040};
  bcrf_alu_e  fns [6] = '{ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_SHL, ALU_ROR};
  logic [7:0] fexp [6] = '{8'h33, 8'h22, 8'h77, 8'h55, 8'hcc, 8'h33};

  always #4 sys_clk = ~sys_clk;

  bcrf_regfile u_bcrf_regfile (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_op(instr_op), .alu_fn(alu_fn),
    .src_addr(src_addr), .dst_addr(dst_addr), .use_imm(use_imm), .imm_data(imm_data),
    .dst_write(dst_write), .idx_sel(idx_sel), .idx_mode(idx_mode), .iw_wait(iw_wait),
    .dw_wait(dw_wait), .rx_data(rx_data), .mem_rd_data(mem_rd_data), .ready(ready),
    .done(done), .fetch_next(fetch_next), .tx_push(tx_push), .tx_data(tx_data),
    .rx_pop(rx_pop), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data), .mem_we(mem_we),
    .mem_re(mem_re), .prog_we(prog_we), .bank_a_alt(bank_a_alt),
    .bank_b_alt(bank_b_alt), .gie(gie));

  bcrf_far_model u_bcrf_far_model (.sys_clk(sys_clk), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data), .mem_we(mem_we), .mem_re(mem_re), .rx_pop(rx_pop),
    .mem_rd_data(mem_rd_data), .rx_data(rx_data));

  task automatic summarize();
    $display("tests %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(logic [15:0] seen, logic [15:0] exp, string msg);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one instruction: offer at a falling edge, count t-states up to done
  task automatic go(bcrf_op_e op, bcrf_alu_e fn, logic [4:0] s, logic [4:0] d,
                    logic [7:0] im, logic ui, logic w, int t);
    int n;
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_op = op;
    alu_fn = fn;
    src_addr = s;
    dst_addr = d;
    imm_data = im;
    use_imm = ui;
    dst_write = w;
    chk({15'h0, ready}, 16'h1, "ready before offer");
    @(negedge sys_clk);
    instr_valid = 1'b0;
    // first sample lands half a cycle after the taking edge
    n = 1;
    n1 = {ready, fetch_next, rx_pop, prog_we, mem_we, mem_re};
    n1_addr = mem_addr;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    dn = {tx_push, ready};
    dn_txd = tx_data;
    chk(16'(n), 16'(t), "t-state count");
    chk({14'h0, n1[5:4]}, 16'h1, "fetch overlap");
  endtask

  // register read-back through a data memory write at address zero
  task automatic rd(logic [4:0] l, logic [7:0] v);
    idx_sel = 2'h3;
    idx_mode = IDX_HOLD;
    go(OP_MWR, ALU_PASS, l, 5'h00, 8'h00, 1'b0, 1'b0, 4);
    chk({8'h0, u_bcrf_far_model.mem[0]}, {8'h0, v}, "register value");
  endtask

  // locations above 15 need a move, since immediates stop at 15
  task automatic wr(logic [4:0] l, logic [7:0] v);
    if (l < 5'h10)
      go(OP_LDI, ALU_PASS, 5'h00, l, v, 1'b1, 1'b1, 2);
    else
    begin
      go(OP_LDI, ALU_PASS, 5'h00, 5'h0a, v, 1'b1, 1'b1, 2);
      go(OP_MOVE, ALU_PASS, 5'h0a, l, 8'h00, 1'b0, 1'b1, 2);
    end
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk({9'h0, ready, bank_a_alt, bank_b_alt, gie, done, mem_we, tx_push},
        16'h0070, "reset outputs");
    rd(5'h18, 8'h00);
    foreach (rows[i]) wr(rows[i].loc, rows[i].val);
    foreach (rows[i]) rd(rows[i].loc, rows[i].val);
    go(OP_LDI, ALU_PASS, 5'h00, 5'h15, 8'h5c, 1'b1, 1'b1, 2);
    rd(5'h05, 8'h5c);
    rd(5'h15, 8'h95);
    // accumulator as second operand, written only when named
    wr(5'h08, 8'h11);
    wr(5'h05, 8'h22);
    go(OP_ALU, ALU_ADD, 5'h05, 5'h06, 8'h00, 1'b0, 1'b1, 2);
    rd(5'h06, 8'h33);
    rd(5'h08, 8'h11);
    go(OP_ALU, ALU_ADD, 5'h05, 5'h08, 8'h00, 1'b0, 1'b1, 2);
    rd(5'h08, 8'h33);
    go(OP_ALU, ALU_ADD, 5'h06, 5'h06, 8'h00, 1'b0, 1'b1, 2);
    rd(5'h06, 8'h66);
    go(OP_ALU, ALU_ADD, 5'h06, 5'h06, 8'h00, 1'b0, 1'b0, 2);
    rd(5'h06, 8'h66);
    // alu functions other than add and pass, operand 66 against accumulator 33
    foreach (fns[j])
    begin
      go(OP_ALU, fns[j], 5'h06, 5'h07, 8'h00, 1'b0, 1'b1, 2);
      rd(5'h07, fexp[j]);
    end
    // line data port in the alternate b bank
    wr(5'h04, 8'h7e);
    chk({7'h0, dn[1], dn_txd}, 16'h017e, "transmit push");
    go(OP_MOVE, ALU_PASS, 5'h04, 5'h09, 8'h00, 1'b0, 1'b1, 2);
    chk({15'h0, n1[3]}, 16'h1, "receive pop");
    rd(5'h09, 8'hc0);
    // main and alternate banks hold separate contents
    wr(5'h01, 8'ha1);
    wr(5'h09, 8'ha9);
    go(OP_EXX, ALU_PASS, 5'h00, 5'h00, 8'h00, 1'b1, 1'b0, 2);
    wr(5'h01, 8'h31);
    wr(5'h09, 8'h39);
    wr(5'h04, 8'h34);
    chk({15'h0, dn[1]}, 16'h0, "no push from main bank");
    rd(5'h01, 8'h31);
    rd(5'h09, 8'h39);
    rd(5'h04, 8'h34);
    go(OP_EXX, ALU_PASS, 5'h00, 5'h00, 8'h03, 1'b1, 1'b0, 2);
    rd(5'h01, 8'ha1);
    rd(5'h09, 8'ha9);
    for (int c = 0; c < 4; c++)
    begin
      go(OP_EXX, ALU_PASS, 5'h00, 5'h00, {4'h0, c == 3, c == 0, 2'(c)}, 1'b1, 1'b0, 2);
      chk({13'h0, bank_a_alt, bank_b_alt, gie}, {13'h0, c[0], c[1], c != 3},
          "bank select");
    end
    // t-state counts with instruction and data wait states
    for (int k = 0; k < 6; k++)
    begin
      iw_wait = 2'(tiw[k]);
      dw_wait = 3'(tdw[k]);
      go(tops[k], ALU_ADD, 5'h09, 5'h09, 8'h00, 1'b0, 1'b0, tt[k]);
      chk({13'h0, n1[2:0]}, {13'h0, tfl[k]}, "memory strobes");
    end
    iw_wait = 2'h0;
    dw_wait = 3'h0;
    // index 0 stepping through post-increment, post-decrement and hold
    wr(5'h0c, 8'h40);
    for (int k = 0; k < 4; k++)
    begin
      idx_sel = 2'h0;
      idx_mode = modes[k];
      go(OP_MRD, ALU_PASS, 5'h00, 5'h09, 8'h00, 1'b0, 1'b1, 4);
      chk(n1_addr, exa[k], "index address");
      rd(5'h09, exa[k][7:0] ^ 8'h5a);
    end
    // reset in mid-run returns both groups to the alternate banks
    go(OP_EXX, ALU_PASS, 5'h00, 5'h00, 8'h04, 1'b1, 1'b0, 2);
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk({13'h0, bank_a_alt, bank_b_alt, gie}, 16'h0006, "banks after reset");
    rd(5'h09, 8'h00);
    summarize();
  end
endmodule // tb_banked_cpu_register_file
`default_nettype wire
